// ===== core/opfd_align_if.sv
// Carrier between the decode core and its address aligner
`timescale 1ns/1ns
interface opfd_align_if #(parameter int ADDR_W = 32);
   import opfd_pkg::*;
   logic [ADDR_W-1:0] addr;
   opfd_size_t size;
   logic fetch;
   logic [ADDR_W-1:0] aligned;
   logic [ADDR_W-1:0] last;
   logic [3:0] nbytes;
   modport core (output addr, size, fetch, input aligned, last, nbytes);
   modport align (input addr, size, fetch, output aligned, last, nbytes);
endinterface

// ===== core/opfd_mem_align.sv
// Forced even alignment and byte span of memory accesses
`timescale 1ns/1ns
module opfd_mem_align
   import opfd_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF
) (
   opfd_align_if.align a
);
   logic wide;

   // Odd word, longword or fetch address drops to the even byte below,
   // no error is raised for it
   always_comb begin
      wide = (a.size == SZ_WORD) || (a.size == SZ_LONG) || a.fetch;
      a.aligned = a.addr;
      if (wide) begin
         a.aligned[0] = 1'b0;
      end
   end

   // Most significant byte sits at the even address, rest ascend
   always_comb begin
      case (a.size)
         SZ_WORD: a.nbytes = BYTES_W;
         SZ_LONG: a.nbytes = BYTES_L;
         default: a.nbytes = BYTES_B;
      endcase
      a.last = a.aligned + ADDR_W'(a.nbytes - 4'h1);
   end
endmodule

// ===== core/opfd_pkg.sv
// Constants and types shared by the operand-format decode block
package opfd_pkg;

   // Instruction type indices, 65 types in eight groups
   localparam logic [6:0] NUM_TYPES = 7'h41;
   localparam logic [6:0] T_REG_XFER = 7'h00;
   localparam logic [6:0] T_STACK = 7'h01;
   localparam logic [6:0] T_MULTI = 7'h02;
   localparam logic [6:0] T_PSYNC_LD = 7'h03;
   localparam logic [6:0] T_PSYNC_ST = 7'h04;
   localparam logic [6:0] T_ADD_CARRY = 7'h09;
   localparam logic [6:0] T_SUB_BORROW = 7'h0A;
   localparam logic [6:0] T_DEC_ADJ_ADD = 7'h0B;
   localparam logic [6:0] T_DEC_ADJ_SUB = 7'h0C;
   localparam logic [6:0] T_PTR_ADD = 7'h0F;
   localparam logic [6:0] T_PTR_SUB = 7'h10;
   localparam logic [6:0] T_MUL_U = 7'h11;
   localparam logic [6:0] T_DIV_S = 7'h14;
   localparam logic [6:0] T_EXT_U = 7'h15;
   localparam logic [6:0] T_EXT_S = 7'h16;
   localparam logic [6:0] T_TEST_SET = 7'h17;

   // First index of each group after the transfer group
   localparam logic [6:0] G_ARITH_FIRST = 7'h05;
   localparam logic [6:0] G_LOGIC_FIRST = 7'h18;
   localparam logic [6:0] G_SHIFT_FIRST = 7'h1C;
   localparam logic [6:0] G_BIT_FIRST = 7'h24;
   localparam logic [6:0] G_BRANCH_FIRST = 7'h32;
   localparam logic [6:0] G_SYS_FIRST = 7'h37;
   localparam logic [6:0] G_BLOCK_FIRST = 7'h40;

   typedef enum logic [2:0] {
      GRP_XFER = 3'h0, GRP_ARITH = 3'h1, GRP_LOGIC = 3'h2, GRP_SHIFT = 3'h3,
      GRP_BIT = 3'h4, GRP_BRANCH = 3'h5, GRP_SYS = 3'h6, GRP_BLOCK = 3'h7
   } opfd_group_t;

   typedef enum logic [1:0] {
      SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2, SZ_NONE = 2'h3
   } opfd_size_t;

   typedef enum logic [1:0] {
      STK_NONE = 2'h0, STK_POSTINC = 2'h1, STK_PREDEC = 2'h2
   } opfd_stack_t;

   // Allowed-size masks, bit index is the opfd_size_t value
   localparam logic [3:0] M_BWL = 4'h7;
   localparam logic [3:0] M_WL = 4'h6;
   localparam logic [3:0] M_BW = 4'h3;
   localparam logic [3:0] M_B = 4'h1;
   localparam logic [3:0] M_L = 4'h4;
   localparam logic [3:0] M_NONE = 4'h8;

   localparam logic [3:0] BYTES_B = 4'h1;
   localparam logic [3:0] BYTES_W = 4'h2;
   localparam logic [3:0] BYTES_L = 4'h4;

   localparam logic [2:0] SP_INDEX = 3'h7;
   localparam logic [7:0] TEST_SET_REG_MASK = 8'h33;
   localparam logic [3:0] BCD_MAX = 4'h9;
   localparam int ADDR_W_DEF = 32;

endpackage

// ===== core/opfd_top.sv
// Operand-format and instruction-class decode front end
//
// What this block does
// - Operands of bit, packed BCD, byte, word and longword size are handled.
// - Bit instructions select bit 0 to 7 of a byte operand.
// - Decimal adjust instructions see their byte as two packed BCD digits.
// - Odd word or longword addresses drop bit 0, no address error.
// - Instruction fetch addresses drop bit 0 the same way, no error.
// - Sixty-five instruction types are sorted into eight groups.
// - Both peripheral-synchronous byte transfers are unsupported here.
// - Multi-register save and restore are longword only, never register 7.
// - Pop is post-increment, push pre-decrement, through the stack pointer.
// - Multiply/divide byte or word; pointer add longword; carry add byte.
// - All eight shifts and rotates accept byte, word or longword.
// - All fourteen bit-manipulation instructions are byte only.
`timescale 1ns/1ns
module opfd_top
   import opfd_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic req_valid,
   input wire logic [6:0] req_type,
   input wire logic [1:0] req_size,
   input wire logic req_fetch,
   input wire logic req_push,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [2:0] req_areg,
   input wire logic [7:0] req_reglist,
   input wire logic [2:0] req_bitnum,
   input wire logic [7:0] req_data,
   output logic out_valid,
   output logic out_legal,
   output logic out_unsupported,
   output logic out_size_err,
   output logic out_reg_err,
   output logic out_sp_warn,
   output logic [2:0] out_group,
   output logic [1:0] out_stack,
   output logic [ADDR_W-1:0] out_addr,
   output logic [ADDR_W-1:0] out_last,
   output logic [3:0] out_nbytes,
   output logic [7:0] out_bit_mask,
   output logic out_bit_val,
   output logic [3:0] out_bcd_hi,
   output logic [3:0] out_bcd_lo,
   output logic out_bcd_ok
);

   ////////////////////////////////////////////////////////////////////////
   // Decode functions

   // Group by index range; indices past the last type fall in the block group
   function automatic opfd_group_t type_group(input logic [6:0] t);
      if (t < G_ARITH_FIRST) return GRP_XFER;
      else if (t < G_LOGIC_FIRST) return GRP_ARITH;
      else if (t < G_SHIFT_FIRST) return GRP_LOGIC;
      else if (t < G_BIT_FIRST) return GRP_SHIFT;
      else if (t < G_BRANCH_FIRST) return GRP_BIT;
      else if (t < G_SYS_FIRST) return GRP_BRANCH;
      else if (t < G_BLOCK_FIRST) return GRP_SYS;
      else return GRP_BLOCK;
   endfunction

   // Operand sizes each type accepts
   function automatic logic [3:0] size_mask(input logic [6:0] t);
      logic [3:0] m;
      m = M_BWL;
      case (type_group(t))
         GRP_XFER: begin
            case (t)
               T_STACK: m = M_WL;
               T_MULTI: m = M_L;
               T_PSYNC_LD, T_PSYNC_ST: m = M_B;
               default: m = M_BWL;
            endcase
         end
         GRP_ARITH: begin
            if (t == T_ADD_CARRY || t == T_SUB_BORROW) m = M_B;
            else if (t == T_DEC_ADJ_ADD || t == T_DEC_ADJ_SUB) m = M_B;
            else if (t == T_TEST_SET) m = M_B;
            else if (t == T_PTR_ADD || t == T_PTR_SUB) m = M_L;
            else if (t >= T_MUL_U && t <= T_DIV_S) m = M_BW;
            else if (t == T_EXT_U || t == T_EXT_S) m = M_WL;
            else m = M_BWL;
         end
         GRP_SHIFT: m = M_BWL;
         GRP_BIT: m = M_B;
         GRP_BRANCH, GRP_SYS, GRP_BLOCK: m = M_NONE;
         default: m = M_BWL;
      endcase
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Address alignment

   opfd_align_if #(.ADDR_W(ADDR_W)) al ();

   assign al.addr = req_addr;
   assign al.size = opfd_size_t'(req_size);
   assign al.fetch = req_fetch;

   opfd_mem_align #(.ADDR_W(ADDR_W)) u_align (
      .a(al)
   );

   ////////////////////////////////////////////////////////////////////////
   // Result stage: one registered answer per accepted request

   logic next_valid, next_legal, next_unsup, next_size_err, next_reg_err;
   logic next_sp_warn, next_bit_val, next_bcd_ok;
   logic [2:0] next_group;
   logic [1:0] next_stack;
   logic [ADDR_W-1:0] next_addr, next_last;
   logic [3:0] next_nbytes, next_bcd_hi, next_bcd_lo;
   logic [7:0] next_bit_mask;
   logic known, is_bcd;
   logic [3:0] allowed;
   opfd_group_t grp;

   // Checks are combinational so the answer lands on the next edge
   always_comb begin
      grp = type_group(req_type);
      known = req_type < NUM_TYPES;
      is_bcd = (req_type == T_DEC_ADJ_ADD) || (req_type == T_DEC_ADJ_SUB);
      next_valid = req_valid;
      next_group = grp;
      next_unsup = (req_type == T_PSYNC_LD) || (req_type == T_PSYNC_ST)
                   || !known;
      // A call result cannot be indexed directly, so the mask is held first
      allowed = size_mask(req_type);
      next_size_err = !allowed[req_size];
      next_reg_err = 1'b0;
      // Register 7 is the stack pointer, never in a save/restore list
      if (req_type == T_MULTI && req_reglist[SP_INDEX]) begin
         next_reg_err = 1'b1;
      end
      // Flagged so software faults show up, the core cannot prevent them
      if (req_type == T_TEST_SET && !TEST_SET_REG_MASK[req_areg]) begin
         next_reg_err = 1'b1;
      end
      next_sp_warn = (req_areg == SP_INDEX) && (req_size == SZ_BYTE)
                     && (grp != GRP_BIT);
      next_stack = STK_NONE;
      // Stack forms use the ordinary transfer path with auto-modify
      if (req_type == T_STACK || req_type == T_MULTI) begin
         next_stack = req_push ? STK_PREDEC : STK_POSTINC;
      end
      next_legal = !next_unsup && !next_size_err && !next_reg_err;
      next_addr = al.aligned;
      next_last = al.last;
      next_nbytes = al.nbytes;
      next_bit_mask = 8'h01 << req_bitnum;
      next_bit_val = req_data[req_bitnum];
      next_bcd_hi = req_data[7:4];
      next_bcd_lo = req_data[3:0];
      next_bcd_ok = is_bcd && (req_data[7:4] <= BCD_MAX)
                    && (req_data[3:0] <= BCD_MAX);
      if (!req_valid) begin
         next_legal = 1'b0;
         next_unsup = 1'b0;
         next_size_err = 1'b0;
         next_reg_err = 1'b0;
         next_sp_warn = 1'b0;
         next_bcd_ok = 1'b0;
      end
   end

   // Output register; every port comes straight from here
   always_ff @(posedge clk) begin
      if (srst) begin
         out_valid <= 1'b0;
         out_legal <= 1'b0;
         out_unsupported <= 1'b0;
         out_size_err <= 1'b0;
         out_reg_err <= 1'b0;
         out_sp_warn <= 1'b0;
         out_group <= 3'h0;
         out_stack <= 2'h0;
         out_addr <= '0;
         out_last <= '0;
         out_nbytes <= 4'h0;
         out_bit_mask <= 8'h00;
         out_bit_val <= 1'b0;
         out_bcd_hi <= 4'h0;
         out_bcd_lo <= 4'h0;
         out_bcd_ok <= 1'b0;
      end else begin
         out_valid <= next_valid;
         out_legal <= next_legal;
         out_unsupported <= next_unsup;
         out_size_err <= next_size_err;
         out_reg_err <= next_reg_err;
         out_sp_warn <= next_sp_warn;
         out_group <= next_group;
         out_stack <= next_stack;
         out_addr <= next_addr;
         out_last <= next_last;
         out_nbytes <= next_nbytes;
         out_bit_mask <= next_bit_mask;
         out_bit_val <= next_bit_val;
         out_bcd_hi <= next_bcd_hi;
         out_bcd_lo <= next_bcd_lo;
         out_bcd_ok <= next_bcd_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   a_even_wide: assert property (@(posedge clk) disable iff (srst)
      ($past(req_valid) && $past(req_size) != SZ_BYTE
       && $past(req_size) != SZ_NONE) |-> out_addr[0] == 1'b0
       && out_addr[ADDR_W-1:1] == $past(req_addr[ADDR_W-1:1]))
      else $error("wide access address not forced even");

   a_fetch_even: assert property (@(posedge clk) disable iff (srst)
      (req_valid && req_fetch) |=> out_addr[0] == 1'b0
      && out_addr[ADDR_W-1:1] == $past(req_addr[ADDR_W-1:1]))
      else $error("fetch address not forced even");

   a_psync_off: assert property (@(posedge clk) disable iff (srst)
      (req_valid && (req_type == T_PSYNC_LD || req_type == T_PSYNC_ST))
      |=> out_valid && out_unsupported && !out_legal)
      else $error("peripheral-synchronous transfer not refused");

   a_mul_sizes: assert property (@(posedge clk) disable iff (srst)
      (req_valid && req_type >= T_MUL_U && req_type <= T_DIV_S)
      |=> out_size_err == ($past(req_size) == SZ_LONG
                           || $past(req_size) == SZ_NONE))
      else $error("multiply or divide size check wrong");

   a_multi_sp: assert property (@(posedge clk) disable iff (srst)
      (req_valid && req_type == T_MULTI && req_reglist[7]) |=> out_reg_err)
      else $error("register 7 accepted in register list");

   a_bit_sel: assert property (@(posedge clk) disable iff (srst)
      req_valid |=> $onehot(out_bit_mask)
      && out_bit_val == $past(req_data[req_bitnum])
      && out_bit_mask[$past(req_bitnum)])
      else $error("bit selection does not follow bit number");

   a_bit_bytes: assert property (@(posedge clk) disable iff (srst)
      (req_valid && type_group(req_type) == GRP_BIT && req_size != SZ_BYTE)
      |=> out_size_err && out_group == GRP_BIT)
      else $error("bit instruction accepted a wide size");

   a_stack_dir: assert property (@(posedge clk) disable iff (srst)
      (req_valid && req_type == T_STACK) |=>
      out_stack == ($past(req_push) ? STK_PREDEC : STK_POSTINC))
      else $error("stack addressing mode wrong");

   a_span_msb: assert property (@(posedge clk) disable iff (srst)
      (req_valid && req_size == SZ_LONG) |=> out_nbytes == BYTES_L
      && out_last == out_addr + ADDR_W'(3))
      else $error("longword byte span wrong");

   a_answer_one: assert property (@(posedge clk) disable iff (srst)
      req_valid |=> out_valid ##1 (out_valid == $past(req_valid)))
      else $error("answer not one cycle after request");

endmodule

// ===== tb/opfd_mem_model.sv
// Behavioural memory holding program code and data for the bench
`timescale 1ns/1ns
module opfd_mem_model (
   input wire logic clk,
   input wire logic en,
   input wire logic [31:0] addr,
   input wire logic [3:0] nbytes,
   output logic [31:0] rdata
);
   logic [7:0] mem [0:15];
   logic [31:0] held = 32'h0;

   //////////////////////////////////////////////////
   // Bytes are read from the given address upward, first byte is the MSB
   always_comb begin
      rdata = ~held; // Idle bus must not echo the last read
      if (en) begin
         rdata = 32'h0;
         for (int i = 0; i < 4; i++) begin
            if (i < nbytes) begin
               rdata = {rdata[23:0], mem[4'(addr[3:0] + 4'(i))]};
            end
         end
      end
   end

   // Remember the last value so an idle bus reads something else
   always @(posedge clk) begin
      held <= rdata;
   end

   // Each byte holds its own offset plus a marker nibble
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 8'h10 + 8'(i);
      end
   end
endmodule

// ===== tb/opfd_top_tb.sv
// Self-checking bench for the operand-format decode front end
`timescale 1ns/1ns
module opfd_top_tb;
   import opfd_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic req_valid = 1'b0;
   logic req_fetch = 1'b0;
   logic req_push = 1'b0;
   logic [6:0] req_type = 7'h00;
   logic [1:0] req_size = 2'h0;
   logic [31:0] req_addr = 32'h0;
   logic [2:0] req_areg = 3'h0;
   logic [7:0] req_reglist = 8'h00;
   logic [2:0] req_bitnum = 3'h0;
   logic [7:0] req_data = 8'h00;
   logic out_valid, out_legal, out_unsupported, out_size_err;
   logic out_reg_err, out_sp_warn, out_bit_val, out_bcd_ok;
   logic [2:0] out_group;
   logic [1:0] out_stack;
   logic [31:0] out_addr, out_last, mem_rdata;
   logic [3:0] out_nbytes, out_bcd_hi, out_bcd_lo;
   logic [7:0] out_bit_mask;
   int mismatches = 0;
   int checks_done = 0;

   // 25 MHz core clock
   always #20 clk = ~clk;

   opfd_top DUT (
      .clk(clk), .srst(srst), .req_valid(req_valid), .req_type(req_type),
      .req_size(req_size), .req_fetch(req_fetch), .req_push(req_push),
      .req_addr(req_addr), .req_areg(req_areg), .req_reglist(req_reglist),
      .req_bitnum(req_bitnum), .req_data(req_data),
      .out_valid(out_valid), .out_legal(out_legal),
      .out_unsupported(out_unsupported), .out_size_err(out_size_err),
      .out_reg_err(out_reg_err), .out_sp_warn(out_sp_warn),
      .out_group(out_group), .out_stack(out_stack), .out_addr(out_addr),
      .out_last(out_last), .out_nbytes(out_nbytes),
      .out_bit_mask(out_bit_mask), .out_bit_val(out_bit_val),
      .out_bcd_hi(out_bcd_hi), .out_bcd_lo(out_bcd_lo),
      .out_bcd_ok(out_bcd_ok)
   );

   // Memory on the far side reads whatever the decoder points at
   opfd_mem_model far_mem (.clk(clk), .en(out_valid), .addr(out_addr),
      .nbytes(out_nbytes), .rdata(mem_rdata));

   //////////////////////////////////////////////////
   // Allowed sizes per type, bit index is the size code
   function automatic logic [3:0] allow(input int t);
      if (t <= 4) return t == 0 ? 4'h7 : t == 1 ? 4'h6 : t == 2 ? 4'h4 : 4'h1;
      if (t inside {[9:12], 23, [36:49]}) return 4'h1;
      if (t inside {15, 16}) return 4'h4;
      if (t inside {[17:20]}) return 4'h3;
      if (t inside {21, 22}) return 4'h6;
      if (t >= 50) return 4'h8;
      return 4'h7;
   endfunction

   // Group from the running sum of the group sizes
   function automatic logic [2:0] grp(input int t);
      int f[8] = '{0, 5, 24, 28, 36, 50, 55, 64};
      grp = 3'h0;
      for (int g = 0; g < 8; g++) if (t >= f[g]) grp = 3'(g);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
         input string m);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // Inputs change at the falling edge; answer is one cycle later
   task automatic req(input logic [6:0] t, input logic [1:0] s,
         input logic [31:0] a);
      req_valid = 1'b1;
      req_type = t;
      req_size = s;
      req_addr = a;
      @(negedge clk);
      chk(out_valid, 1'b1, "valid");
   endtask

   task automatic idle();
      req_valid = 1'b0;
      @(negedge clk);
      chk(out_valid, 1'b0, "idle");
      chk(out_legal, 1'b0, "idle legal");
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   //////////////////////////////////////////////////
   // Back-to-back push and pop at odd addresses, then a plain byte
   task automatic t_walk;
      req_push = 1'b1;
      req(7'h01, 2'h1, 32'h1001);
      chk(out_stack, 2'h2, "push mode");
      chk(out_addr, 32'h1000, "push addr");
      chk(out_last, 32'h1001, "push last");
      chk(out_nbytes, 4'h2, "push bytes");
      chk(mem_rdata, 32'h1011, "word data");
      chk(out_legal, 1'b1, "push legal");
      req_push = 1'b0;
      req(7'h01, 2'h2, 32'h1003);
      chk(out_stack, 2'h1, "pop mode");
      chk(out_addr, 32'h1002, "pop addr");
      chk(out_last, 32'h1005, "pop last");
      chk(mem_rdata, 32'h12131415, "long data");
      req(7'h00, 2'h0, 32'h1003);
      chk(out_addr, 32'h1003, "byte addr");
      chk(out_stack, 2'h0, "no stack");
      chk(mem_rdata, 32'h13, "byte data");
      idle();
      $display("walk done");
   endtask

   // Fetches drop bit 0 whatever the size
   task automatic t_fetch;
      req_fetch = 1'b1;
      req(7'h37, 2'h3, 32'h2007);
      chk(out_addr, 32'h2006, "sys fetch");
      chk(out_legal, 1'b1, "fetch legal");
      req(7'h00, 2'h0, 32'h2005);
      chk(out_addr, 32'h2004, "byte fetch");
      req_fetch = 1'b0;
      req(7'h37, 2'h3, 32'h2007);
      chk(out_addr, 32'h2007, "no fetch");
      $display("fetch done");
   endtask

   // Every type with every size code, then types past the end
   task automatic t_sweep;
      logic [3:0] m;
      for (int t = 0; t < 65; t++) begin
         m = allow(t);
         for (int s = 0; s < 4; s++) begin
            req(7'(t), 2'(s), 32'h0);
            chk(out_group, grp(t), "group");
            chk(out_size_err, !m[s], "size");
            chk(out_unsupported, t inside {3, 4}, "unsup");
            chk(out_legal, m[s] && !(t inside {3, 4}), "legal");
         end
      end
      for (int t = 65; t < 128; t += 62) begin
         req(7'(t), 2'h0, 32'h0);
         chk(out_unsupported, 1'b1, "unsup high");
         chk(out_legal, 1'b0, "legal high");
      end
      $display("sweep done");
   endtask

   // Register choice checks for test-and-set, stack pointer byte use and multi save
   task automatic t_regs;
      for (int a = 0; a < 8; a++) begin
         req_areg = 3'(a);
         req(7'h17, 2'h0, 32'h0);
         chk(out_reg_err, !(a inside {0, 1, 4, 5}), "test-set reg");
         chk(out_sp_warn, a == 7, "sp byte");
      end
      req(7'h24, 2'h0, 32'h0);
      chk(out_sp_warn, 1'b0, "sp bit op");
      req(7'h00, 2'h1, 32'h0);
      chk(out_sp_warn, 1'b0, "sp word");
      req_areg = 3'h0;
      req_reglist = 8'h80;
      req(7'h02, 2'h2, 32'h0);
      chk(out_reg_err, 1'b1, "list sp");
      chk(out_legal, 1'b0, "list legal");
      req_reglist = 8'h7F;
      req(7'h02, 2'h2, 32'h0);
      chk(out_reg_err, 1'b0, "list ok");
      req_reglist = 8'h00;
      $display("regs done");
   endtask

   // Bit select over all positions, then packed digit cases
   task automatic t_bits;
      logic [7:0] d[4] = '{8'h59, 8'h5A, 8'hA0, 8'h99};
      logic [6:0] ty[4] = '{7'h0B, 7'h0C, 7'h0C, 7'h00};
      req_data = 8'hA5;
      for (int b = 0; b < 8; b++) begin
         req_bitnum = 3'(b);
         req(7'h24, 2'h0, 32'h0);
         chk(out_bit_mask, 8'h01 << b, "mask");
         chk(out_bit_val, req_data[b], "bit val");
      end
      for (int i = 0; i < 4; i++) begin
         req_data = d[i];
         req(ty[i], 2'h0, 32'h0);
         chk(out_bcd_hi, d[i][7:4], "bcd hi");
         chk(out_bcd_lo, d[i][3:0], "bcd lo");
         chk(out_bcd_ok, d[i][7:4] <= 4'h9 && d[i][3:0] <= 4'h9
            && ty[i] != 7'h00, "bcd ok");
      end
      $display("bits done");
   endtask

   // Reset for six cycles, then run every scenario
   initial begin
      repeat (6) @(negedge clk);
      chk(out_valid, 1'b0, "rst valid");
      chk(out_addr, 32'h0, "rst addr");
      srst = 1'b0;
      idle();
      t_walk();
      t_fetch();
      t_sweep();
      t_regs();
      t_bits();
      test_done();
   end
endmodule
